// ===== hw/pmc_pkg.sv
package pmc_pkg;

  // ==========================================================================
  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_MAP_ONE  = 4'h0;
  localparam logic [3:0] ADDR_MAP_TWO  = 4'h1;
  localparam logic [3:0] ADDR_CONFIG   = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h5;

  // ==========================================================================
  // Field positions and reset values.
  localparam int PIN0_LSB = 6;
  localparam int PIN1_LSB = 4;
  localparam int PIN2_LSB = 2;
  localparam int PIN3_LSB = 0;
  localparam int PIN4_LSB = 6;
  localparam int PIN5_LSB = 4;
  localparam int CFG_PKT_BIT  = 0;
  localparam int CFG_SYNC_BIT = 1;
  localparam logic [7:0] MAP_ONE_RST = 8'h00;
  localparam logic [7:0] MAP_TWO_RST = 8'h00;
  localparam logic [1:0] CONFIG_RST  = 2'h1;
  localparam logic [3:0] IRQ_RST     = 4'h0;

  // Interrupt status bits: sync match, payload ready, packet sent, fifo full.
  localparam int IRQ_SYNC = 0;
  localparam int IRQ_PAYL = 1;
  localparam int IRQ_SENT = 2;
  localparam int IRQ_FULL = 3;

  // ==========================================================================
  // Operating state codes coming from the sequencer.
  localparam logic [2:0] OP_SLEEP = 3'h0;
  localparam logic [2:0] OP_STBY  = 3'h1;
  localparam logic [2:0] OP_FS    = 3'h2;
  localparam logic [2:0] OP_RX    = 3'h3;
  localparam logic [2:0] OP_TX    = 3'h4;

  // ==========================================================================
  // Bit timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_PERIOD_NS = 800;
  localparam logic [7:0] HALF_BIT_CYCLES = 8'(BIT_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // ==========================================================================
  // Link state machine.
  typedef enum logic [3:0] {
    LNK_IDLE   = 4'h1,
    LNK_TX     = 4'h2,
    LNK_RX_RAW = 4'h4,
    LNK_RX_SYN = 4'h8
  } pmc_link_t;

  typedef struct packed {
    logic [7:0] map_one;
    logic [7:0] map_two;
    logic [1:0] cfg;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic [3:0] ev_prev;
    logic [7:0] rdata;
    logic       irq;
    pmc_link_t  link;
    logic [7:0] cnt;
    logic       ck;
    logic       dat;
    logic       dat_oe;
    logic       tx_bit;
    logic       prev_demod;
    logic [5:0] pins;
    logic       pkt_en;
  } pmc_state_t;

endpackage : pmc_pkg

// ===== hw/pmc_sync2.sv
`timescale 1ns/1ps

module pmc_sync2 (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second.
  logic meta_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : pmc_sync2

// ===== hw/pmc_top.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - Six output pins each carry a signal picked by a 2-bit code from two mapping registers, pin 2 only in packet mode.
// - Continuous mode pin 0 gives sync match, rssi/preamble or receive-ready per code.
// - Packet mode pin 0 gives payload/sent or crc, pin 1 gives fifo level, empty or full.
// - Continuous mode passes raw bits on the data pin and keeps the packet handler off.
// - Continuous transmit drives a bit clock on the pin 1 clock function.
// - Continuous transmit captures the data pin on each rising bit clock edge.
// - Receive without bit synchroniser gives raw demodulator data and no clock.
// - Receive with bit synchroniser gives retimed data and the recovered clock.
// - Synchronised receive data change on the falling clock edge or at a demodulator transition with the clock held low, sampled on the rising.
// - Packet mode forces the bit synchroniser on whatever software sets.
// - The fifo-empty flag is high exactly when the fifo holds no bytes.

module pmc_top #(
  parameter logic [7:0] HALF_BIT = pmc_pkg::HALF_BIT_CYCLES
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            irq_o,
  input  wire logic [2:0] op_state_i,
  input  wire logic       sync_match_i,
  input  wire logic       transmit_ready_i,
  input  wire logic       receive_ready_i,
  input  wire logic       rssi_preamble_i,
  input  wire logic       payload_ready_a_i,
  input  wire logic       packet_sent_b_i,
  input  wire logic       crc_good_i,
  input  wire logic       fifo_level_flag_i,
  input  wire logic       fifo_full_flag_i,
  input  wire logic [6:0] fifo_count_i,
  input  wire logic       mode_settled_i,
  input  wire logic       demod_bit_i,
  output logic            tx_bit_o,
  output logic            pkt_handler_en_o,
  output logic            gp_pin_0_o,
  output logic            gp_pin_1_o,
  input  wire logic       gp_pin_2_i,
  output logic            gp_pin_2_o,
  output logic            gp_pin_2_oe_o,
  output logic            gp_pin_3_o,
  output logic            gp_pin_4_o,
  output logic            gp_pin_5_o
);

  // ==========================================================================
  // Data pin input from the external controller.
  logic data_sync;

  pmc_sync2 u_data_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (gp_pin_2_i),
    .sync_o  (data_sync)
  );

  // ==========================================================================
  // State and next state.
  pmc_pkg::pmc_state_t s;
  pmc_pkg::pmc_state_t n;
  logic                pkt;
  logic                eff_sync;
  logic                fifo_empty;
  logic [3:0]          ev_now;
  logic [3:0]          ev_set;
  logic [3:0]          clr;
  logic                in_rx;
  logic                in_tx;
  logic [1:0]          c0;
  logic [1:0]          c1;
  logic [1:0]          c2;
  logic [1:0]          c3;
  logic [1:0]          c4;
  logic [1:0]          c5;

  always_comb begin
    n          = s;
    pkt        = s.cfg[pmc_pkg::CFG_PKT_BIT];
    eff_sync   = pkt | s.cfg[pmc_pkg::CFG_SYNC_BIT];
    fifo_empty = (fifo_count_i == 7'h00);
    in_rx      = (op_state_i == pmc_pkg::OP_RX);
    in_tx      = (op_state_i == pmc_pkg::OP_TX);
    c0         = s.map_one[pmc_pkg::PIN0_LSB +: 2];
    c1         = s.map_one[pmc_pkg::PIN1_LSB +: 2];
    c2         = s.map_one[pmc_pkg::PIN2_LSB +: 2];
    c3         = s.map_one[pmc_pkg::PIN3_LSB +: 2];
    c4         = s.map_two[pmc_pkg::PIN4_LSB +: 2];
    c5         = s.map_two[pmc_pkg::PIN5_LSB +: 2];
    ev_now     = {fifo_full_flag_i, packet_sent_b_i, payload_ready_a_i, sync_match_i};
    ev_set     = ev_now & ~s.ev_prev;
    clr        = 4'h0;
    n.ev_prev  = ev_now;

    // ========================================================================
    // Register port.
    n.rdata = 8'h00;
    if (reg_wr_i) begin
      case (reg_addr_i)
        pmc_pkg::ADDR_MAP_ONE:  n.map_one  = reg_wdata_i;
        pmc_pkg::ADDR_MAP_TWO:  n.map_two  = {reg_wdata_i[7:4], 4'h0};
        pmc_pkg::ADDR_CONFIG:   n.cfg      = reg_wdata_i[1:0];
        pmc_pkg::ADDR_IRQ_STAT: clr        = reg_wdata_i[3:0];
        pmc_pkg::ADDR_IRQ_MASK: n.irq_mask = reg_wdata_i[3:0];
        default:                clr        = 4'h0;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        pmc_pkg::ADDR_MAP_ONE:  n.rdata = s.map_one;
        pmc_pkg::ADDR_MAP_TWO:  n.rdata = s.map_two;
        pmc_pkg::ADDR_CONFIG:   n.rdata = {6'h00, s.cfg};
        pmc_pkg::ADDR_IRQ_STAT: n.rdata = {4'h0, s.irq_st};
        pmc_pkg::ADDR_IRQ_MASK: n.rdata = {4'h0, s.irq_mask};
        pmc_pkg::ADDR_STATUS:   n.rdata = {3'h0, s.link[3:1], fifo_empty, eff_sync};
        default:                n.rdata = 8'h00;
      endcase
    end
    // A new event beats a clear in the same cycle.
    n.irq_st = (s.irq_st & ~clr) | ev_set;
    n.irq    = |(s.irq_st & s.irq_mask);

    // ========================================================================
    // Continuous link state.
    if (!pkt && in_tx) begin
      n.link = pmc_pkg::LNK_TX;
    end else if (!pkt && in_rx) begin
      n.link = eff_sync ? pmc_pkg::LNK_RX_SYN : pmc_pkg::LNK_RX_RAW;
    end else begin
      n.link = pmc_pkg::LNK_IDLE;
    end
    n.pkt_en     = pkt;
    n.prev_demod = demod_bit_i;

    if (n.link != s.link) begin
      n.cnt = 8'h00;
      n.ck  = 1'b0;
    end else begin
      case (s.link)
        pmc_pkg::LNK_TX: begin
          if (s.cnt == HALF_BIT - 8'h01) begin
            n.cnt = 8'h00;
            n.ck  = ~s.ck;
          end else begin
            n.cnt = s.cnt + 8'h01;
          end
          if (n.ck && !s.ck) begin
            n.tx_bit = data_sync;
          end
        end
        pmc_pkg::LNK_RX_SYN: begin
          if (demod_bit_i != s.prev_demod) begin
            n.cnt = 8'h00;
            n.ck  = 1'b0;
            n.dat = demod_bit_i;
          end else if (s.cnt == HALF_BIT - 8'h01) begin
            n.cnt = 8'h00;
            n.ck  = ~s.ck;
            if (s.ck) begin
              n.dat = demod_bit_i;
            end
          end else begin
            n.cnt = s.cnt + 8'h01;
          end
        end
        pmc_pkg::LNK_RX_RAW: begin
          n.ck  = 1'b0;
          n.dat = demod_bit_i;
        end
        default: begin
          n.ck  = 1'b0;
          n.cnt = 8'h00;
        end
      endcase
    end

    // ========================================================================
    // Pin mapping; anything unassigned stays low.
    // Unmapped pins low.
    n.pins   = 6'h00;
    n.dat_oe = 1'b1;
    if (!pkt) begin
      case (c0)
        2'h0:    n.pins[0] = in_rx ? sync_match_i : (in_tx & transmit_ready_i);
        2'h1:    n.pins[0] = in_rx & rssi_preamble_i;
        2'h2:    n.pins[0] = in_rx ? receive_ready_i : (in_tx & transmit_ready_i);
        default: n.pins[0] = 1'b0;
      endcase
      case (c1)
        2'h0:    n.pins[1] = n.ck;
        2'h1:    n.pins[1] = in_rx & rssi_preamble_i;
        default: n.pins[1] = 1'b0;
      endcase
      n.pins[3] = (c3 == 2'h1) & in_rx & rssi_preamble_i;
      n.pins[4] = (c4 == 2'h3) & (op_state_i != pmc_pkg::OP_SLEEP) & mode_settled_i;
      case (c5)
        2'h2:    n.pins[5] = in_rx & rssi_preamble_i;
        2'h3:    n.pins[5] = (op_state_i != pmc_pkg::OP_SLEEP) & mode_settled_i;
        default: n.pins[5] = 1'b0;
      endcase
      // Data pin carries the bit stream.
      n.dat_oe  = (n.link != pmc_pkg::LNK_TX);
      n.pins[2] = (n.link == pmc_pkg::LNK_IDLE) ? 1'b0 : n.dat;
    end else begin
      case (c0)
        2'h0:    n.pins[0] = in_rx ? payload_ready_a_i : (in_tx & packet_sent_b_i);
        2'h1:    n.pins[0] = in_rx & crc_good_i;
        default: n.pins[0] = 1'b0;
      endcase
      case (c1)
        2'h0:    n.pins[1] = fifo_level_flag_i;
        2'h1:    n.pins[1] = fifo_empty;
        2'h2:    n.pins[1] = fifo_full_flag_i;
        default: n.pins[1] = 1'b0;
      endcase
      case (c2)
        2'h0:    n.pins[2] = fifo_full_flag_i;
        2'h1:    n.pins[2] = in_rx & receive_ready_i;
        2'h2:    n.pins[2] = (op_state_i != pmc_pkg::OP_FS) & fifo_full_flag_i;
        default: n.pins[2] = in_rx ? sync_match_i : fifo_full_flag_i;
      endcase
      n.pins[3] = (c3 == 2'h1) ? (in_tx & transmit_ready_i) : fifo_empty;
      n.pins[4] = (c4 == 2'h3) & in_rx & rssi_preamble_i;
      n.pins[5] = (c5 == 2'h3) & (op_state_i != pmc_pkg::OP_SLEEP) & mode_settled_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s          <= '0;
      s.map_one  <= pmc_pkg::MAP_ONE_RST;
      s.map_two  <= pmc_pkg::MAP_TWO_RST;
      s.cfg      <= pmc_pkg::CONFIG_RST;
      s.irq_st   <= pmc_pkg::IRQ_RST;
      s.irq_mask <= pmc_pkg::IRQ_RST;
      s.link     <= pmc_pkg::LNK_IDLE;
      s.dat_oe   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register.
  assign reg_rdata_o      = s.rdata;
  assign irq_o            = s.irq;
  assign tx_bit_o         = s.tx_bit;
  assign pkt_handler_en_o = s.pkt_en;
  assign gp_pin_0_o       = s.pins[0];
  assign gp_pin_1_o       = s.pins[1];
  assign gp_pin_2_o       = s.pins[2];
  assign gp_pin_2_oe_o    = s.dat_oe;
  assign gp_pin_3_o       = s.pins[3];
  assign gp_pin_4_o       = s.pins[4];
  assign gp_pin_5_o       = s.pins[5];

  // ==========================================================================
  // Checks. The period check assumes the default half bit of four cycles.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_cont_pin0_sync: assert property (
    (!pkt && in_rx && c0 == 2'h0) |=> (gp_pin_0_o == $past(sync_match_i)))
    else $error("pin 0 does not follow sync match");
  a_pkt_pin0_sent: assert property (
    (pkt && in_tx && c0 == 2'h0) |=> (gp_pin_0_o == $past(packet_sent_b_i)))
    else $error("pin 0 does not follow packet sent");
  a_fifo_empty_pin: assert property (
    (pkt && c1 == 2'h1) |=> (gp_pin_1_o == $past(fifo_count_i == 7'h00)))
    else $error("empty flag wrong on pin 1");
  a_unmapped_low: assert property (
    (c1 == 2'h3) |=> !gp_pin_1_o)
    else $error("unmapped pin 1 not low");
  a_tx_capture_edge: assert property (
    ($rose(s.ck) && s.link == pmc_pkg::LNK_TX) |-> (tx_bit_o == $past(data_sync)))
    else $error("transmit bit not captured on rising clock");
  a_tx_clk_period: assert property (
    disable iff (!rst_n_i || n.link != pmc_pkg::LNK_TX)
    ($rose(s.ck) && s.link == pmc_pkg::LNK_TX) |-> (s.ck[*4] ##1 !s.ck))
    else $error("bit clock high phase wrong length");
  a_raw_no_clock: assert property (
    (s.link == pmc_pkg::LNK_RX_RAW && c1 == 2'h0 && !pkt)[*2]
      |-> (!gp_pin_1_o && gp_pin_2_o == $past(demod_bit_i)))
    else $error("raw receive shows clock or wrong data");
  a_rx_fall_update: assert property (
    (s.link == pmc_pkg::LNK_RX_SYN && $past(s.link) == pmc_pkg::LNK_RX_SYN
      && $changed(s.dat)) |-> !s.ck)
    else $error("receive data changed while clock high");
  a_pkt_forces_sync: assert property (
    (reg_rd_i && reg_addr_i == pmc_pkg::ADDR_STATUS && pkt) |=> reg_rdata_o[0])
    else $error("bit synchroniser not forced in packet mode");
  a_pkt_handler_off: assert property (
    (!pkt && $past(!pkt)) |-> !pkt_handler_en_o)
    else $error("packet handler active in continuous mode");
  a_irq_set_wins: assert property (
    (ev_set[0] && clr[0]) |=> s.irq_st[0])
    else $error("event lost against clear");
  a_irq_level: assert property (
    ##1 (irq_o == $past(|(s.irq_st & s.irq_mask))))
    else $error("interrupt output wrong");
  a_tx_pin_released: assert property (
    (s.link == pmc_pkg::LNK_TX) |-> !gp_pin_2_oe_o)
    else $error("data pin driven during transmit");
  a_raw_pin_driven: assert property (
    (s.link == pmc_pkg::LNK_RX_RAW) |-> gp_pin_2_oe_o)
    else $error("data pin not driven in raw receive");
  a_sync_clock_pin: assert property (
    ($past(!pkt && c1 == 2'h0) && s.link == pmc_pkg::LNK_RX_SYN) |-> (gp_pin_1_o == s.ck))
    else $error("recovered clock missing on pin 1");
  a_pkt_pin2_map: assert property (
    (pkt && c2 == 2'h0) |=> (gp_pin_2_o == $past(fifo_full_flag_i)))
    else $error("pin 2 does not follow fifo full");
  a_cont_pin1_rssi: assert property (
    (!pkt && in_rx && c1 == 2'h1) |=> (gp_pin_1_o == $past(rssi_preamble_i)))
    else $error("pin 1 does not follow preamble detect");

  c_tx_capture: cover property ($rose(s.ck) && s.link == pmc_pkg::LNK_TX);
  c_rx_sync_fall: cover property ($fell(s.ck) && s.link == pmc_pkg::LNK_RX_SYN);
  c_irq_raise: cover property ($rose(irq_o));
  c_empty_pin: cover property (pkt && c1 == 2'h1 ##1 $rose(gp_pin_1_o));

endmodule : pmc_top

// ===== tb/pmc_mcu_model.sv
`timescale 1ns/1ps

// ==========================================================================
// External controller on the continuous data link.
module pmc_mcu_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        bit_clock_out_i,
  input  wire logic        data_i,
  input  wire logic        dev_oe_i,
  input  wire logic        tx_en_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] pattern_i,
  output logic             data_o,
  output logic             data_oe_o,
  output logic             rx_bit_o,
  output logic             rx_stb_o
);
  logic       bit_clock_out_r;
  logic       tx_en_r;
  logic [1:0] rise_r;
  logic [3:0] idx_r;
  logic       step;

  // The next bit is moved just after a rising clock edge, never near the next one.
  // paced by clock
  assign step      = slow_i ? rise_r[1] : (bit_clock_out_i & ~bit_clock_out_r);
  assign data_o    = pattern_i[idx_r];
  assign data_oe_o = tx_en_i & ~dev_oe_i;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bit_clock_out_r   <= 1'b0;
      tx_en_r  <= 1'b0;
      rise_r   <= 2'h0;
      idx_r    <= 4'h0;
      rx_bit_o <= 1'b0;
      rx_stb_o <= 1'b0;
    end else begin
      bit_clock_out_r   <= bit_clock_out_i;
      tx_en_r  <= tx_en_i;
      rise_r   <= {rise_r[0], bit_clock_out_i & ~bit_clock_out_r};
      rx_stb_o <= 1'b0;
      if (tx_en_i & ~tx_en_r) begin
        idx_r <= 4'h0;
      end else if (tx_en_i & step) begin
        idx_r <= idx_r + 4'h1;
      end
      if (!tx_en_i && bit_clock_out_i && !bit_clock_out_r) begin
        rx_bit_o <= data_i;
        rx_stb_o <= 1'b1;
      end
    end
  end
endmodule : pmc_mcu_model

// ===== tb/tb_pmc_top.sv
`timescale 1ns/1ps

// ==========================================================================
// Bench for the pin mapper and the continuous bit link.
module tb_pmc_top;
  localparam logic [7:0] HALF = 8'h04;
  logic        mclk_i;
  logic        rst_n_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        irq_o;
  logic [2:0]  op_state_i;
  logic [9:0]  flg;
  logic [6:0]  fifo_count_i;
  logic        demod_bit_i;
  logic        tx_bit_o;
  logic        pkt_handler_en_o;
  logic [5:0]  pin_o;
  logic        pin2_oe;
  logic        pin2_in;
  logic        last_lvl = 1'b0;
  logic        mcu_d;
  logic        mcu_oe;
  logic        rx_bit;
  logic        rx_stb;
  logic        tx_en;
  logic        slow;
  logic [15:0] pat;
  logic [3:0]  dm_hist = 4'h0;
  logic        pk;
  logic        bs;
  logic        prv;
  logic        p1;
  logic        r;
  logic [1:0]  c0;
  logic [1:0]  c1;
  logic [7:0]  cc;
  logic [2:0]  e3;
  logic [7:0]  d;
  int          n_fail;
  int          total_checks;
  int          seed;
  int          k;
  int          n;
  int          s;

  pmc_top #(.HALF_BIT(HALF)) i_pmc_top (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .op_state_i(op_state_i), .sync_match_i(flg[0]), .transmit_ready_i(flg[1]),
    .receive_ready_i(flg[2]), .rssi_preamble_i(flg[3]), .payload_ready_a_i(flg[4]),
    .packet_sent_b_i(flg[5]), .crc_good_i(flg[6]), .fifo_level_flag_i(flg[7]),
    .fifo_full_flag_i(flg[8]), .fifo_count_i(fifo_count_i), .mode_settled_i(flg[9]),
    .demod_bit_i(demod_bit_i), .tx_bit_o(tx_bit_o), .pkt_handler_en_o(pkt_handler_en_o),
    .gp_pin_0_o(pin_o[0]), .gp_pin_1_o(pin_o[1]), .gp_pin_2_i(pin2_in),
    .gp_pin_2_o(pin_o[2]), .gp_pin_2_oe_o(pin2_oe), .gp_pin_3_o(pin_o[3]),
    .gp_pin_4_o(pin_o[4]), .gp_pin_5_o(pin_o[5]));

  pmc_mcu_model i_pmc_mcu_model (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bit_clock_out_i(pin_o[1]), .data_i(pin_o[2]),
    .dev_oe_i(pin2_oe), .tx_en_i(tx_en), .slow_i(slow), .pattern_i(pat),
    .data_o(mcu_d), .data_oe_o(mcu_oe), .rx_bit_o(rx_bit), .rx_stb_o(rx_stb));

  // An undriven data line has no pull, so it toggles rather than holding a stale level.
  assign pin2_in = pin2_oe ? pin_o[2] : (mcu_oe ? mcu_d : ~last_lvl);

  always @(posedge mclk_i) begin
    last_lvl <= pin2_in;
    dm_hist  <= {dm_hist[2:0], demod_bit_i};
  end

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // Bus tasks, checks and expectations.
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask : rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  function automatic logic e_pin0(input logic p, input logic [2:0] op, input logic [1:0] c,
                                  input logic [9:0] f);
    logic rx;
    logic tx;
    rx = (op == pmc_pkg::OP_RX);
    tx = (op == pmc_pkg::OP_TX);
    if (p) return (c == 2'h0) ? (rx ? f[4] : (tx & f[5])) : ((c == 2'h1) & rx & f[6]);
    case (c)
      2'h0: return rx ? f[0] : (tx & f[1]);
      2'h1: return rx & f[3];
      2'h2: return rx ? f[2] : (tx & f[1]);
      default: return 1'b0;
    endcase
  endfunction : e_pin0

  function automatic logic e_pin1(input logic p, input logic [2:0] op, input logic [1:0] c,
                                  input logic [9:0] f, input logic [6:0] q);
    // Continuous code 00 is the bit clock, still low three cycles after a mode entry.
    if (!p) return (c == 2'h1) & (op == pmc_pkg::OP_RX) & f[3];
    case (c)
      2'h0: return f[7];
      2'h1: return q == 7'h00;
      2'h2: return f[8];
      default: return 1'b0;
    endcase
  endfunction : e_pin1

  function automatic logic e_pin2(input logic [2:0] op, input logic [1:0] c,
                                  input logic [9:0] f);
    case (c)
      2'h0: return f[8];
      2'h1: return (op == pmc_pkg::OP_RX) & f[2];
      2'h2: return (op != pmc_pkg::OP_FS) & f[8];
      default: return (op == pmc_pkg::OP_RX) ? f[0] : f[8];
    endcase
  endfunction : e_pin2

  function automatic logic [2:0] e_pin345(input logic p, input logic [2:0] op,
                                          input logic [5:0] c, input logic [9:0] f,
                                          input logic [6:0] q);
    logic rx;
    logic up;
    rx = (op == pmc_pkg::OP_RX);
    up = (op != pmc_pkg::OP_SLEEP) & f[9];
    if (p) return {(c[1:0] == 2'h3) & up, (c[3:2] == 2'h3) & rx & f[3],
                   (c[5:4] == 2'h1) ? ((op == pmc_pkg::OP_TX) & f[1]) : (q == 7'h00)};
    return {((c[1:0] == 2'h2) & rx & f[3]) | ((c[1:0] == 2'h3) & up),
            (c[3:2] == 2'h3) & up, (c[5:4] == 2'h1) & rx & f[3]};
  endfunction : e_pin345

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    conclude();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    seed = 15663;
    n_fail = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    op_state_i = pmc_pkg::OP_STBY;
    flg = 10'h000;
    fifo_count_i = 7'h00;
    demod_bit_i = 1'b0;
    tx_en = 1'b0;
    slow = 1'b0;
    pat = 16'h0000;
    cyc(2);
    rst_n_i <= 1'b1;
    rd(pmc_pkg::ADDR_MAP_ONE, d);
    chk(d, pmc_pkg::MAP_ONE_RST, "map one reset");
    rd(pmc_pkg::ADDR_CONFIG, d);
    chk(d, {6'h00, pmc_pkg::CONFIG_RST}, "config reset");
    rd(4'hf, d);
    chk(d, 8'h00, "unmapped read");
    wr(pmc_pkg::ADDR_MAP_TWO, 8'hff);
    rd(pmc_pkg::ADDR_MAP_TWO, d);
    chk(d, 8'hf0, "map two readback");
    for (k = 0; k < 48; k++) begin
      pk = 1'($random(seed));
      bs = 1'($random(seed));
      c0 = 2'($random(seed));
      c1 = 2'($random(seed));
      cc = 8'($random(seed));
      @(posedge mclk_i);
      op_state_i <= pmc_pkg::OP_STBY;
      wr(pmc_pkg::ADDR_CONFIG, {6'h00, bs, pk});
      wr(pmc_pkg::ADDR_MAP_ONE, {c0, c1, cc[7:4]});
      wr(pmc_pkg::ADDR_MAP_TWO, {cc[3:0], 4'h0});
      @(posedge mclk_i);
      op_state_i <= 3'($unsigned($random(seed)) % 5);
      flg <= 10'($random(seed));
      fifo_count_i <= ($random(seed) & 1) ? 7'h00 : 7'($unsigned($random(seed)) % 64 + 1);
      cyc(3);
      #1;
      chk(8'(pin_o[0]), 8'(e_pin0(pk, op_state_i, c0, flg)), "pin0 map");
      r = e_pin1(pk, op_state_i, c1, flg, fifo_count_i);
      chk(8'(pin_o[1]), 8'(r), "pin1 map");
      e3 = e_pin345(pk, op_state_i, cc[5:0], flg, fifo_count_i);
      chk(8'(pin_o[5:3]), 8'(e3), "pins 3 to 5");
      if (pk) chk(8'(pin_o[2]), 8'(e_pin2(op_state_i, cc[7:6], flg)), "packet pin2");
      chk(8'(pkt_handler_en_o), 8'(pk), "handler enable");
      rd(pmc_pkg::ADDR_STATUS, d);
      chk(8'(d[1:0]), {6'h00, fifo_count_i == 7'h00, pk | bs}, "status");
    end
    @(posedge mclk_i);
    flg <= 10'h000;
    op_state_i <= pmc_pkg::OP_STBY;
    wr(pmc_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(pmc_pkg::ADDR_IRQ_STAT, 8'h0f);
    @(posedge mclk_i);
    flg <= 10'h001;
    rd(pmc_pkg::ADDR_IRQ_STAT, d);
    chk(d, 8'h01, "sticky status");
    chk(8'(irq_o), 8'h00, "masked irq");
    wr(pmc_pkg::ADDR_IRQ_MASK, 8'h01);
    cyc(2);
    #1;
    chk(8'(irq_o), 8'h01, "unmasked irq");
    wr(pmc_pkg::ADDR_IRQ_STAT, 8'h01);
    cyc(2);
    #1;
    chk(8'(irq_o), 8'h00, "cleared irq");
    @(posedge mclk_i);
    flg <= 10'h000;
    fork
      wr(pmc_pkg::ADDR_IRQ_STAT, 8'h01);
      @(posedge mclk_i) flg <= 10'h001;
    join
    rd(pmc_pkg::ADDR_IRQ_STAT, d);
    chk(d, 8'h01, "set beats clear");
    wr(pmc_pkg::ADDR_CONFIG, 8'h00);
    wr(pmc_pkg::ADDR_MAP_ONE, 8'h00);
    @(posedge mclk_i);
    op_state_i <= pmc_pkg::OP_RX;
    cyc(6);
    prv = demod_bit_i;
    for (k = 0; k < 40; k++) begin
      @(posedge mclk_i);
      demod_bit_i <= 1'($random(seed));
      #1;
      chk(8'(pin_o[2]), 8'(prv), "raw data");
      chk(8'(pin_o[1]), 8'h00, "no clock raw");
      prv = demod_bit_i;
    end
    wr(pmc_pkg::ADDR_CONFIG, 8'h02);
    cyc(10);
    #1;
    n = 0;
    prv = pin_o[2];
    fork
      for (s = 0; s < 24; s++) begin
        @(posedge mclk_i);
        demod_bit_i <= 1'($random(seed));
        cyc(7);
      end
      repeat (192) begin
        @(posedge mclk_i);
        #1;
        if (rx_stb) chk(8'(rx_bit), 8'(dm_hist[3]), "retimed data");
        if (pin_o[2] !== prv) chk(8'(pin_o[1]), 8'h00, "data moved at high clock");
        prv = pin_o[2];
        n = n + int'(rx_stb);
      end
    join
    chk(8'(n > 18), 8'h01, "recovered clock");
    for (s = 0; s < 2; s++) begin
      @(posedge mclk_i);
      op_state_i <= pmc_pkg::OP_STBY;
      tx_en <= 1'b0;
      cyc(2);
      pat <= 16'($random(seed));
      tx_en <= 1'b1;
      slow <= 1'(s);
      cyc(3);
      op_state_i <= pmc_pkg::OP_TX;
      for (k = 0; k < 16; k++) begin
        n = 0;
        p1 = pin_o[1];
        do begin
          @(posedge mclk_i);
          #1;
          n++;
          r = (pin_o[1] === 1'b1) && (p1 === 1'b0);
          p1 = pin_o[1];
        end while (!r && n < 40);
        chk(8'(tx_bit_o), 8'(pat[k]), "captured bit");
        if (k > 0) chk(8'(n), 8'(2 * HALF), "bit clock period");
        chk(8'(pin2_oe), 8'h00, "data pin released");
      end
    end
    conclude();
  end
endmodule : tb_pmc_top
